// ### bench/frp_apb_host.sv
// Host model: APB master for the rate, precompensation and media register block.
// Assumes one rising-edge clock shared with the block and a zero-wait slave.
`timescale 1ns/10ps
`default_nettype none

module frp_apb_host (
    input  wire logic                  clk,
    output var  frp_pkg::frp_apb_req_t apbReq,
    input  wire frp_pkg::frp_apb_rsp_t apbRsp
);
    import frp_pkg::*;

    initial apbReq = '0;

    // Request stays fixed until pready is seen at a rising edge
    task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
                        output logic [31:0] q, output logic err);
        @(posedge clk);
        apbReq <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a,
                    pwdata: d & 32'hffff_ffdf};
        @(posedge clk);
        apbReq.penable <= 1'b1;
        do
            @(posedge clk);
        while (apbRsp.pready !== 1'b1);
        q = apbRsp.prdata;
        err = apbRsp.pslverr;
        apbReq <= '0;
    endtask
endmodule

`default_nettype wire

// ### bench/tb_frp_rate_regs.sv
// Self-checking bench for the rate, precompensation and media register block.
// Assumes the host model drives APB; the bench holds configuration and pins.
`timescale 1ns/10ps
`default_nettype none

module tb_frp_rate_regs;
    import frp_pkg::*;

    logic         clk = 1'b0;
    logic         rstn = 1'b0;
    logic         ce = 1'b1;
    logic         swResetIn = 1'b0;
    logic         hostStatusAccess = 1'b0;
    logic         ratePinLowIn = 1'b0;
    logic         ratePinHighIn = 1'b0;
    logic [7:0]   curTrack = 8'h00;
    logic [7:0]   precompStartTrack = 8'h00;
    frp_cfg_t     cfg = '0;
    frp_apb_req_t apbReq;
    frp_apb_rsp_t apbRsp;
    logic         ratePinLowOut;
    logic         ratePinLowOen;
    logic         ratePinHighOut;
    logic         ratePinHighOen;
    logic         densitySelectOut;
    frp_rate_t    dataRate;
    logic [5:0]   shiftCycles;
    logic         precompActive;
    logic         lowPower;
    logic         softResetPulse;
    int           nMismatch = 0;
    int           compares = 0;
    int           nPulse = 0;
    logic [31:0]  q;
    logic         err;
    logic [5:0]   shTab [8] = '{6'h19, 6'h09, 6'h11, 6'h1a, 6'h22, 6'h2a, 6'h33, 6'h00};

    always #2.5 clk = ~clk;

    always @(posedge clk)
        if (softResetPulse === 1'b1)
            nPulse <= nPulse + 1;

    frp_apb_host frp_apb_host_inst (.clk(clk), .apbReq(apbReq), .apbRsp(apbRsp));

    frp_rate_regs #(.TRACK_W(8)) frp_rate_regs_inst (
        .clk(clk), .rstn(rstn), .ce(ce), .apbReq(apbReq), .apbRsp(apbRsp), .cfg(cfg),
        .swResetIn(swResetIn), .hostStatusAccess(hostStatusAccess), .curTrack(curTrack),
        .precompStartTrack(precompStartTrack), .ratePinLowIn(ratePinLowIn),
        .ratePinHighIn(ratePinHighIn), .ratePinLowOut(ratePinLowOut),
        .ratePinLowOen(ratePinLowOen), .ratePinHighOut(ratePinHighOut),
        .ratePinHighOen(ratePinHighOen), .densitySelectOut(densitySelectOut),
        .dataRate(dataRate), .shiftCycles(shiftCycles), .precompActive(precompActive),
        .lowPower(lowPower), .softResetPulse(softResetPulse));

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            nMismatch++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // Lets flopped outputs land, then samples away from the rising edge
    task automatic settle();
        repeat (2) @(posedge clk);
        @(negedge clk);
    endtask

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        frp_apb_host_inst.xfer(1'b1, a, {24'h0, d}, q, err);
        settle();
    endtask

    task automatic rd(input logic [11:0] a);
        frp_apb_host_inst.xfer(1'b0, a, 32'h0, q, err);
    endtask

    // One-cycle sideband pulse: 1 = status access, 0 = software reset
    task automatic pulse(input bit hs);
        @(posedge clk);
        if (hs)
            hostStatusAccess <= 1'b1;
        else
            swResetIn <= 1'b1;
        @(posedge clk);
        hostStatusAccess <= 1'b0;
        swResetIn <= 1'b0;
        settle();
    endtask

    function automatic frp_rate_t expRate(input int t, input int c);
        case (c)
            3: return RATE_1M;
            0: return RATE_500K;
            2: return RATE_250K;
            default: return t == 0 ? RATE_300K : (t == 1 ? RATE_500K : RATE_2M);
        endcase
    endfunction

    function automatic logic [5:0] expShift(input frp_rate_t r);
        return r == RATE_2M ? 6'h05 : (r == RATE_1M ? 6'h09 : 6'h19);
    endfunction

    task automatic results();
        $display("checks %0d mismatches %0d", compares, nMismatch);
        if (nMismatch == 0 && compares > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    initial
    begin
        repeat (20000) @(posedge clk);
        nMismatch++;
        $display("mismatch watchdog expected end seen hang");
        results();
    end

    initial
    begin
        repeat (6) @(posedge clk);
        rstn <= 1'b1;
        @(negedge clk);
        chk("rate rst", dataRate, RATE_250K);
        chk("shift rst", shiftCycles, 6'h19);
        rd(ADDR_STATUS);
        chk("status rst", q, 32'h0000_0088);
        $display("test reset done");

        for (int t = 0; t < 3; t++)
            for (int c = 0; c < 4; c++)
            begin
                @(posedge clk);
                cfg.driveRateType <= 2'(t);
                cfg.ident <= 1'b1;
                wr(ADDR_RATE_WRITE_SHIFT_SELECT, 8'(c));
                chk("rate", dataRate, expRate(t, c));
                chk("shift def", shiftCycles, expShift(expRate(t, c)));
                chk("density", densitySelectOut, 32'(c == 0 || c == 3));
                chk("pins", {ratePinHighOut, ratePinLowOut, ratePinHighOen, ratePinLowOen},
                    {2'(c), 2'b00});
                @(posedge clk);
                cfg.ident <= 1'b0;
                settle();
                chk("density inv", densitySelectOut, 32'(c == 1 || c == 2));
            end
        $display("test rate table done");

        for (int p = 0; p < 8; p++)
        begin
            wr(ADDR_RATE_WRITE_SHIFT_SELECT, {3'b000, 3'(p), 2'b10});
            chk("write_shift_select", shiftCycles, shTab[p]);
        end
        $display("test write_shift_select done");

        wr(ADDR_CFG_RATE, 8'h03);
        chk("ccr rate", dataRate, RATE_1M);
        wr(ADDR_RATE_WRITE_SHIFT_SELECT, 8'h00);
        chk("dsr last", dataRate, RATE_500K);
        wr(ADDR_CFG_RATE, 8'h02);
        chk("ccr last", dataRate, RATE_250K);
        rd(ADDR_RATE_WRITE_SHIFT_SELECT);
        chk("dsr wo", {q[30:0], err}, 32'h0);
        rd(ADDR_CFG_RATE);
        chk("ccr wo", {q[30:0], err}, 32'h0);
        rd(12'h100);
        chk("unmapped", err, 32'h1);
        $display("test last write done");

        wr(ADDR_RATE_WRITE_SHIFT_SELECT, 8'h42);
        chk("low power", lowPower, 32'h1);
        pulse(1'b1);
        chk("lp access", lowPower, 32'h0);
        wr(ADDR_RATE_WRITE_SHIFT_SELECT, 8'h42);
        pulse(1'b0);
        chk("lp swrst", lowPower, 32'h0);
        chk("rate swrst", dataRate, RATE_250K);
        wr(ADDR_RATE_WRITE_SHIFT_SELECT, 8'h42);
        nPulse = 0;
        wr(ADDR_RATE_WRITE_SHIFT_SELECT, 8'h83);
        chk("swrst pulse", nPulse, 32'h1);
        chk("lp self rst", lowPower, 32'h0);
        // A frozen block must ignore the access that would wake it
        wr(ADDR_RATE_WRITE_SHIFT_SELECT, 8'h42);
        @(posedge clk);
        ce <= 1'b0;
        pulse(1'b1);
        @(posedge clk);
        ce <= 1'b1;
        settle();
        chk("ce hold", lowPower, 32'h1);
        $display("test low power done");

        @(posedge clk);
        cfg.enhanced2 <= 1'b1;
        cfg.bootMediaCfg <= 8'h09;
        cfg.driveTypeCfg <= 8'he4;
        wr(ADDR_TAPE_MEDIA, 8'h02);
        for (int k = 0; k < 4; k++)
        begin
            @(posedge clk);
            cfg.driveSel <= 2'(k);
            {ratePinHighIn, ratePinLowIn} <= 2'(k);
            settle();
            rd(ADDR_TAPE_MEDIA);
            chk("media", q, {24'h0, ~k[1], k[0], 2'(k), 4'h6});
            chk("pins in", {ratePinHighOen, ratePinLowOen}, 32'h3);
        end
        pulse(1'b0);
        @(posedge clk);
        rstn <= 1'b0;
        @(posedge clk);
        rstn <= 1'b1;
        settle();
        rd(ADDR_TAPE_MEDIA);
        chk("media rst", q, 32'h0000_0074);
        chk("rate hw rst", dataRate, RATE_250K);
        wr(ADDR_TAPE_MEDIA, 8'h03);
        @(posedge clk);
        cfg.enhanced2 <= 1'b0;
        settle();
        rd(ADDR_TAPE_MEDIA);
        chk("normal", q, 32'h0000_0003);
        $display("test media done");

        @(posedge clk);
        precompStartTrack <= 8'h05;
        curTrack <= 8'h04;
        settle();
        chk("track below", precompActive, 32'h0);
        @(posedge clk);
        curTrack <= 8'h05;
        settle();
        chk("track start", precompActive, 32'h1);
        $display("test track done");
        results();
    end
endmodule

`default_nettype wire

// ### hdl/frp_pkg.sv
// Constants and carrier types for the floppy rate, precompensation and media registers.
// Assumes a 12-bit APB byte address and a 200 MHz controller clock.
package frp_pkg;

    // Printed register indexes; byte address is four times the index
    localparam logic [9:0]  IDX_TAPE_MEDIA   = 10'h3f3;
    localparam logic [9:0]  IDX_RATE_WRITE_SHIFT_SELECT = 10'h3f4;
    localparam logic [9:0]  IDX_CFG_RATE     = 10'h3f7;
    localparam logic [11:0] ADDR_TAPE_MEDIA   = {IDX_TAPE_MEDIA, 2'b00};
    localparam logic [11:0] ADDR_RATE_WRITE_SHIFT_SELECT = {IDX_RATE_WRITE_SHIFT_SELECT, 2'b00};
    localparam logic [11:0] ADDR_CFG_RATE     = {IDX_CFG_RATE, 2'b00};
    localparam logic [11:0] ADDR_STATUS       = 12'h000;

    // Rate/precompensation register fields
    localparam int          RP_RATE_LSB    = 0;
    localparam int          RP_WRITE_SHIFT_SELECT_LSB = 2;
    localparam int          RP_LOWPWR_BIT  = 6;
    localparam int          RP_SWRST_BIT   = 7;
    localparam logic [1:0]  RATE_CODE_RST  = 2'h2;
    localparam logic [2:0]  WRITE_SHIFT_SELECT_RST    = 3'h0;
    localparam logic [2:0]  WRITE_SHIFT_SELECT_OFF    = 3'h7;
    localparam logic [2:0]  WRITE_SHIFT_SELECT_DEF    = 3'h0;

    // Boot/media configuration bit positions
    localparam int          BM_INV1_BIT = 3;
    localparam int          BM_INV0_BIT = 2;

    // Precompensation timing
    localparam int          CLK_PERIOD_PS   = 5000;
    localparam int          WRITE_SHIFT_SELECT_STEP_PS = 41670;
    localparam int          DEF_2M_PS       = 20800;
    localparam int          DEF_1M_PS       = 41670;
    localparam int          DEF_SLOW_PS     = 125000;
    localparam logic [5:0]  DEF_2M_CYC   = 6'((DEF_2M_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
    localparam logic [5:0]  DEF_1M_CYC   = 6'((DEF_1M_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
    localparam logic [5:0]  DEF_SLOW_CYC = 6'((DEF_SLOW_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);

    typedef enum logic [4:0] {
        RATE_250K = 5'h01,
        RATE_300K = 5'h02,
        RATE_500K = 5'h04,
        RATE_1M   = 5'h08,
        RATE_2M   = 5'h10
    } frp_rate_t;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } frp_apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } frp_apb_rsp_t;

    typedef struct packed {
        logic       enhanced2;
        logic       ident;
        logic [1:0] driveOpt;
        logic [7:0] driveTypeCfg;
        logic [7:0] bootMediaCfg;
        logic [1:0] driveRateType;
        logic [1:0] driveSel;
    } frp_cfg_t;

    typedef struct packed {
        frp_apb_rsp_t rsp;
        logic [1:0]   tapeSel;
        logic [1:0]   rateCode;
        logic [2:0]   write_shift_select;
        logic         lowPower;
        logic         swRstBit;
        logic         softResetPulse;
        logic [1:0]   mediaSense;
        logic         density;
        logic [1:0]   ratePinOut;
        logic [1:0]   ratePinOen;
        frp_rate_t    dataRate;
        logic [5:0]   shiftCycles;
        logic         precompActive;
    } frp_state_t;

endpackage

// ### hdl/frp_rate_regs.sv
// Rate select, write precompensation and tape/media registers of a floppy controller.
// Assumes an APB master, configuration held elsewhere and drive pins synchronous to clk.
// Function
// [R1] Enhanced mode two: rate pins are inputs, shown on media bits 7 and 6.
// [R2] Media sense bits ignore hardware and software resets.
// [R3] Bit 7 is second media pin, inverted when boot/media bit 3 set.
// [R4] Bit 6 is first media pin, inverted when boot/media bit 2 set.
// [R5] Bits 5:4 are the drive-type pair of the last selected drive.
// [R6] Bits 3:2 mirror boot/media configuration bits 1:0.
// [R7] Bits 1:0 are a read/write tape select in every mode.
// [R8] Rate select is write only; last write of it or config rate wins.
// [R9] Hardware reset loads 02h; software reset leaves it.
// [R10] Rate code and drive-rate type decode into the data rate.
// [R11] Density output follows rate code, polarity set by ident.
// [R12] Drive option 00 drives rate pins with the rate code bits.
// [R13] Bits 4:2 choose precompensation shift; 111 off, 000 default.
// [R14] Precompensation starts at a programmable track, track 0 by default.
// [R15] Host writes bit 5 as zero.
// [R16] Writing bit 6 enters manual low power.
// [R17] Software reset or data/status access leaves low power.
// [R18] Bit 7 issues a software reset and clears itself.
// [R19] Legacy hosts set rate through the config rate register.
// [R20] Config rate register is write only, bits 1:0, reset to 10.
// [R21] Default shift is 20.8 ns at 2M, 41.67 ns at 1M, else 125 ns.
// [R22] Normal mode: tape/media bits 7:2 are not driven.
// [R23] An outside setting picks normal or enhanced tape/media layout.
`timescale 1ns/10ps
`default_nettype none

module frp_rate_regs #(
    parameter int TRACK_W = 8
) (
    input  wire logic                 clk,
    input  wire logic                 rstn,
    input  wire logic                 ce,
    input  wire frp_pkg::frp_apb_req_t apbReq,
    output var  frp_pkg::frp_apb_rsp_t apbRsp,
    input  wire frp_pkg::frp_cfg_t    cfg,
    input  wire logic                 swResetIn,
    input  wire logic                 hostStatusAccess,
    input  wire logic [TRACK_W-1:0]   curTrack,
    input  wire logic [TRACK_W-1:0]   precompStartTrack,
    input  wire logic                 ratePinLowIn,
    input  wire logic                 ratePinHighIn,
    output logic                      ratePinLowOut,
    output logic                      ratePinLowOen,
    output logic                      ratePinHighOut,
    output logic                      ratePinHighOen,
    output logic                      densitySelectOut,
    output frp_pkg::frp_rate_t        dataRate,
    output logic [5:0]                shiftCycles,
    output logic                      precompActive,
    output logic                      lowPower,
    output logic                      softResetPulse
);
    import frp_pkg::*;

    frp_state_t st;
    frp_state_t next_st;

    logic       setupPh;
    logic       accessPh;
    logic       wrTape;
    logic       wrRate;
    logic       wrCfgRate;
    logic       softHit;
    logic [1:0] mediaNow;
    logic [1:0] driveTypeNow;
    logic [7:0] tapeRead;

    function automatic frp_rate_t decodeRate(input logic [1:0] code, input logic [1:0] drt);
        frp_rate_t r;
        r = RATE_250K;
        unique case (code)
            2'b11: r = RATE_1M;
            2'b00: r = RATE_500K;
            2'b10: r = RATE_250K;
            2'b01:
            begin
                if (drt == 2'b01)
                    r = RATE_500K;
                else if (drt == 2'b10)
                    r = RATE_2M;
                else
                    r = RATE_300K;
            end
        endcase
        return r;
    endfunction

    function automatic logic [5:0] shiftOf(input logic [2:0] code, input frp_rate_t rate);
        logic [5:0] c;
        int         ps;
        c  = 6'h00;
        ps = int'(code) * WRITE_SHIFT_SELECT_STEP_PS;
        if (code == WRITE_SHIFT_SELECT_OFF)
            c = 6'h00;
        else if (code == WRITE_SHIFT_SELECT_DEF)
        begin
            if (rate == RATE_2M)
                c = DEF_2M_CYC;
            else if (rate == RATE_1M)
                c = DEF_1M_CYC;
            else
                c = DEF_SLOW_CYC;
        end
        else
            c = 6'((ps + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
        return c;
    endfunction

    assign setupPh   = apbReq.psel && !apbReq.penable;
    assign accessPh  = apbReq.psel && apbReq.penable && st.rsp.pready;
    assign wrTape    = accessPh && apbReq.pwrite && apbReq.paddr == ADDR_TAPE_MEDIA;
    assign wrRate    = accessPh && apbReq.pwrite && apbReq.paddr == ADDR_RATE_WRITE_SHIFT_SELECT;
    assign wrCfgRate = accessPh && apbReq.pwrite && apbReq.paddr == ADDR_CFG_RATE;
    assign softHit   = swResetIn || (wrRate && apbReq.pwdata[RP_SWRST_BIT]);

    // Media levels pass through the configured inversion
    assign mediaNow = {ratePinHighIn ^ cfg.bootMediaCfg[BM_INV1_BIT],   // R1 R3
                       ratePinLowIn ^ cfg.bootMediaCfg[BM_INV0_BIT]};   // R4
    assign driveTypeNow = cfg.driveTypeCfg[{cfg.driveSel, 1'b0} +: 2];  // R5

    always_comb
    begin
        if (cfg.enhanced2)  // R23
            tapeRead = {st.mediaSense, driveTypeNow, cfg.bootMediaCfg[1:0], st.tapeSel}; // R6
        else
            tapeRead = {6'h00, st.tapeSel};  // R22
    end

    always_comb
    begin
        next_st = st;
        next_st.mediaSense = mediaNow;  // R2
        next_st.rsp.pready = 1'b0;
        next_st.rsp.pslverr = 1'b0;
        next_st.softResetPulse = 1'b0;
        next_st.swRstBit = 1'b0;  // R18

        // One wait-free access phase; read data fixed at the setup edge
        if (setupPh && !st.rsp.pready)
        begin
            next_st.rsp.pready = 1'b1;
            next_st.rsp.prdata = 32'h0000_0000;
            unique case (apbReq.paddr)
                ADDR_TAPE_MEDIA:
                    if (!apbReq.pwrite)
                        next_st.rsp.prdata = {24'h00_0000, tapeRead};
                ADDR_STATUS:
                    if (!apbReq.pwrite)
                        next_st.rsp.prdata = {16'h0000, 3'h0, st.lowPower,
                                              st.dataRate, st.write_shift_select,
                                              st.rateCode, st.tapeSel};
                ADDR_RATE_WRITE_SHIFT_SELECT,
                ADDR_CFG_RATE:
                    next_st.rsp.prdata = 32'h0000_0000;
                default:
                    next_st.rsp.pslverr = 1'b1;
            endcase
        end

        if (wrTape)
            next_st.tapeSel = apbReq.pwdata[1:0];  // R7
        // Whichever register was written last sets the rate
        if (wrCfgRate)
            next_st.rateCode = apbReq.pwdata[1:0];  // R8 R20 R19
        if (wrRate)
        begin
            next_st.rateCode = apbReq.pwdata[RP_RATE_LSB +: 2];  // R8
            // Bit 5 carries nothing and is dropped
            next_st.write_shift_select = apbReq.pwdata[RP_WRITE_SHIFT_SELECT_LSB +: 3];  // R13 R15
        end

        // Leaving low power first, so a new power-down write in the same cycle sticks
        if (softHit || hostStatusAccess)
            next_st.lowPower = 1'b0;  // R17
        if (wrRate && apbReq.pwdata[RP_LOWPWR_BIT])
            next_st.lowPower = 1'b1;  // R16
        if (softHit)
        begin
            next_st.softResetPulse = 1'b1;  // R18
            next_st.swRstBit = wrRate && apbReq.pwdata[RP_SWRST_BIT];
        end

        next_st.dataRate = decodeRate(next_st.rateCode, cfg.driveRateType);  // R10
        next_st.density = cfg.ident ~^ (next_st.rateCode == 2'b11 ||
                                        next_st.rateCode == 2'b00);  // R11
        if (cfg.enhanced2)
        begin
            next_st.ratePinOut = 2'b00;
            next_st.ratePinOen = 2'b11;  // R1
        end
        else if (cfg.driveOpt == 2'b00)
        begin
            next_st.ratePinOut = next_st.rateCode;  // R12
            next_st.ratePinOen = 2'b00;
        end
        else
        begin
            next_st.ratePinOut = 2'b00;
            next_st.ratePinOen = 2'b11;
        end
        next_st.shiftCycles = shiftOf(next_st.write_shift_select, next_st.dataRate);  // R13 R21
        next_st.precompActive = curTrack >= precompStartTrack;  // R14

        // Hardware reset; the media bits keep tracking their pins
        if (!rstn)
        begin
            next_st = '0;
            next_st.mediaSense = mediaNow;  // R2
            next_st.rateCode = RATE_CODE_RST;  // R9 R20
            next_st.write_shift_select = WRITE_SHIFT_SELECT_RST;
            next_st.dataRate = RATE_250K;
            next_st.density = !cfg.ident;
            next_st.ratePinOen = 2'b11;
            next_st.shiftCycles = DEF_SLOW_CYC;
        end
    end

    // Reset acts even while the clock enable holds state
    always_ff @(posedge clk)
    begin
        if (ce || !rstn)
            st <= next_st;
    end

    assign apbRsp           = st.rsp;
    assign ratePinLowOut    = st.ratePinOut[0];
    assign ratePinHighOut   = st.ratePinOut[1];
    assign ratePinLowOen    = st.ratePinOen[0];
    assign ratePinHighOen   = st.ratePinOen[1];
    assign densitySelectOut = st.density;
    assign dataRate         = st.dataRate;
    assign shiftCycles      = st.shiftCycles;
    assign precompActive    = st.precompActive;
    assign lowPower         = st.lowPower;
    assign softResetPulse   = st.softResetPulse;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);

    logic tapeRd;
    assign tapeRd = setupPh && ce && !st.rsp.pready && !apbReq.pwrite
                    && apbReq.paddr == ADDR_TAPE_MEDIA;

    sequence s_swrst_write;
        ce && wrRate && apbReq.pwdata[RP_SWRST_BIT] && !swResetIn;
    endsequence
    sequence s_quiet;
        ce && !softHit;
    endsequence

    a_media_track: assert property (ce |=> st.mediaSense == $past(mediaNow)) // R3 R4
        else $error("media sense bits do not follow pins");
    a_media_reset: assert property (@(posedge clk) disable iff (1'b0)
        !rstn |=> st.mediaSense == $past(mediaNow)) // R2
        else $error("media sense bits disturbed by reset");
    a_drive_type: assert property (tapeRd && cfg.enhanced2
        |=> apbRsp.prdata[5:4] == $past(driveTypeNow)) // R5
        else $error("drive type field wrong");
    a_boot_field: assert property (tapeRd && cfg.enhanced2
        |=> apbRsp.prdata[3:2] == $past(cfg.bootMediaCfg[1:0])) // R6
        else $error("boot drive field wrong");
    a_normal_upper: assert property (tapeRd && !cfg.enhanced2
        |=> apbRsp.prdata[7:2] == 6'h00 && apbRsp.pready) // R22
        else $error("normal mode upper bits not zero");
    a_hw_reset: assert property (@(posedge clk) disable iff (1'b0)
        !rstn |=> st.rateCode == RATE_CODE_RST && st.write_shift_select == WRITE_SHIFT_SELECT_RST) // R9
        else $error("rate register reset value wrong");
    a_rate_2m: assert property (ce && next_st.rateCode == 2'b01
        && cfg.driveRateType == 2'b10 |=> dataRate == RATE_2M) // R10
        else $error("2 Mbps decode wrong");
    a_cfg_rate: assert property (ce && wrCfgRate && !wrRate
        |=> st.rateCode == $past(apbReq.pwdata[1:0])) // R8
        else $error("config rate write lost");
    a_pin_drive: assert property (ce && !cfg.enhanced2 && cfg.driveOpt == 2'b00
        |=> !ratePinLowOen && !ratePinHighOen
            && {ratePinHighOut, ratePinLowOut} == st.rateCode) // R12
        else $error("rate pins not driven from code");
    a_lp_exit: assert property (ce && hostStatusAccess
        && !(wrRate && apbReq.pwdata[RP_LOWPWR_BIT]) |=> !lowPower) // R17
        else $error("low power not left on access");
    a_swrst_clear: assert property (s_swrst_write ##1 s_quiet
        |=> !softResetPulse && !st.swRstBit) // R18
        else $error("software reset bit not self clearing");
    a_write_shift_select_off: assert property (ce && next_st.write_shift_select == WRITE_SHIFT_SELECT_OFF
        |=> shiftCycles == 6'h00) // R13
        else $error("disabled precompensation still shifts");

endmodule

`default_nettype wire
